// ---- pkg/hibpr_pkg.sv ----
/*
 * Constants, bit layout and types shared by the hibernation power and counter block.
 * Assumes a single 50 MHz core clock and a byte-addressed register port.
 */
package hibpr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 9;
	localparam logic [8:0] OFF_COUNT = 9'h000;
	localparam logic [8:0] OFF_MATCH_A = 9'h004;
	localparam logic [8:0] OFF_MATCH_B = 9'h008;
	localparam logic [8:0] OFF_LOAD = 9'h00C;
	localparam logic [8:0] OFF_CTL = 9'h010;
	localparam logic [8:0] OFF_MASK = 9'h014;
	localparam logic [8:0] OFF_RAW = 9'h018;
	localparam logic [8:0] OFF_MASKED = 9'h01C;
	localparam logic [8:0] OFF_CLEAR = 9'h020;
	localparam logic [8:0] OFF_TRIM = 9'h024;
	localparam logic [8:0] OFF_DATA_LO = 9'h030;
	localparam logic [8:0] OFF_DATA_HI = 9'h12C;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTL_W = 8;
	localparam int CTL_COUNTER_EN = 0;
	localparam int CTL_SLEEP_REQ = 1;
	localparam int CTL_OSC_SEL = 2;
	localparam int CTL_MATCH_RES = 3;
	localparam int CTL_PIN_RES = 4;
	localparam int CTL_LB_DETECT = 5;
	localparam int CTL_OSC_EN = 6;
	localparam int CTL_LB_ABORT = 7;

	// ----------------------------------------------------------------
	// Event bits (mask, raw, masked, clear)
	// ----------------------------------------------------------------
	localparam int EV_W = 4;
	localparam int EV_MATCH_A = 0;
	localparam int EV_MATCH_B = 1;
	localparam int EV_LOW_BATT = 2;
	localparam int EV_PIN = 3;

	// ----------------------------------------------------------------
	// Reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [31:0] MATCH_RST = 32'hFFFFFFFF;
	localparam logic [31:0] LOAD_RST = 32'hFFFFFFFF;
	localparam logic [31:0] COUNT_RST = 32'h00000000;
	localparam logic [CTL_W-1:0] CTL_RST = 8'h00;
	localparam logic [EV_W-1:0] EV_RST = 4'h0;
	localparam int TRIM_W = 16;
	localparam logic [TRIM_W-1:0] TRIM_RST = 16'h0000;
	localparam logic [TRIM_W-1:0] TRIM_NOMINAL = 16'h7FFF;
	localparam int DIV_W = 7;
	localparam logic [DIV_W-1:0] DIV_LAST = 7'h7F;
	localparam int SEC_W = 6;
	localparam logic [SEC_W-1:0] SEC_LAST = 6'h3F;
	localparam int MEM_AW = 6;
	localparam int MEM_WORDS = 64;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		PWR_ON = 1'b0,
		PWR_OFF = 1'b1
	} hibpr_pwr_t;

endpackage

// ---- pkg/hibpr_mem_if.sv ----
/*
 * Port bundle between the controller and the retained word store.
 * Assumes both ends share the core clock; read data lag the strobe by one cycle.
 */
interface hibpr_mem_if;
	logic we;
	logic re;
	logic [hibpr_pkg::MEM_AW-1:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport ctrl (
		output we,
		output re,
		output addr,
		output wdata,
		input rdata
	);

	modport mem (
		input we,
		input re,
		input addr,
		input wdata,
		output rdata
	);
endinterface

// ---- verilog/hibpr_mem.sv ----
/*
 * Retained word store: 64 words of 32 bits with registered read data.
 * Assumes one write or read strobe per cycle from the controller.
 */
module hibpr_mem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	hibpr_mem_if.mem bus
);

	typedef struct packed {
		logic [hibpr_pkg::MEM_WORDS-1:0][31:0] words;
		logic [31:0] rdata;
	} hibpr_mem_state_t;

	hibpr_mem_state_t st_q;
	hibpr_mem_state_t st_d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		if (bus.we) begin
			st_d.words[bus.addr] = bus.wdata;
		end
		if (bus.re) begin
			st_d.rdata = st_q.words[bus.addr];
		end
	end

	// Contents live only in this always-on domain, so they outlast the sleep
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign bus.rdata = st_q.rdata;

endmodule

// ---- verilog/hibpr_top.sv ----
/*
 * Hibernation power controller with seconds counter, match logic,
 * low-battery abort, event status and retained words.
 * Assumes OSC_IN, WAKE_N and LOW_BATT are synchronous to CORE_CLK and that
 * the oscillator input toggles well below half the core clock rate.
 */
// The address-and-strobe port and the register addresses are this design's own decisions.
module hibpr_top (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic [hibpr_pkg::ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic OSC_IN,
	input wire logic WAKE_N,
	input wire logic LOW_BATT,
	output logic POWER_OFF_N,
	output logic IRQ
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		hibpr_pkg::hibpr_pwr_t pwr;
		logic [hibpr_pkg::CTL_W-1:0] ctl;
		logic [31:0] cnt;
		logic [31:0] match_a;
		logic [31:0] match_b;
		logic [31:0] load;
		logic [hibpr_pkg::EV_W-1:0] mask;
		logic [hibpr_pkg::EV_W-1:0] raw;
		logic [hibpr_pkg::TRIM_W-1:0] trim;
		logic [hibpr_pkg::TRIM_W-1:0] pre_active;
		logic [hibpr_pkg::TRIM_W-1:0] pre_cnt;
		logic [hibpr_pkg::DIV_W-1:0] div;
		logic [hibpr_pkg::SEC_W-1:0] sec;
		logic osc_prev;
		logic wake_prev;
		logic [1:0] eq;
		logic power_off_n;
		logic irq;
		logic [31:0] rdata;
		logic rd_mem;
	} hibpr_state_t;

	hibpr_state_t st_q;
	hibpr_state_t st_d;

	hibpr_mem_if mem_bus ();

	logic word_ok;
	logic in_data;
	logic [hibpr_pkg::ADDR_W-1:0] data_off;
	logic osc_edge;
	logic ref_tick;
	logic sec_tick;
	logic [1:0] eq_now;
	logic [hibpr_pkg::EV_W-1:0] ev_set;
	logic [hibpr_pkg::EV_W-1:0] ev_clr;
	logic [hibpr_pkg::CTL_W-1:0] ctl_w;
	logic lb_abort;
	logic wake_req;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign word_ok = (ADDR[1:0] == 2'h0);
	assign in_data = word_ok && (ADDR >= hibpr_pkg::OFF_DATA_LO) && (ADDR <= hibpr_pkg::OFF_DATA_HI);
	assign data_off = ADDR - hibpr_pkg::OFF_DATA_LO;

	assign mem_bus.we = WR && in_data;
	assign mem_bus.re = RD && in_data;
	assign mem_bus.addr = data_off[hibpr_pkg::MEM_AW+1:2];
	assign mem_bus.wdata = WDATA;

	hibpr_mem u_mem (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.ce(CE),
		.bus(mem_bus)
	);

	// ----------------------------------------------------------------
	// Timebase
	// ----------------------------------------------------------------
	// Oscillator is sampled, so only rising edges seen by the core clock count
	assign osc_edge = OSC_IN && !st_q.osc_prev && st_q.ctl[hibpr_pkg::CTL_OSC_EN];
	assign ref_tick = osc_edge &&
		(st_q.ctl[hibpr_pkg::CTL_OSC_SEL] || (st_q.div == hibpr_pkg::DIV_LAST));
	assign sec_tick = ref_tick && (st_q.pre_cnt == '0);

	// ----------------------------------------------------------------
	// Events
	// ----------------------------------------------------------------
	assign eq_now[0] = (st_q.cnt == st_q.match_a);
	assign eq_now[1] = (st_q.cnt == st_q.match_b);

	always_comb begin
		ev_set = '0;
		ev_set[hibpr_pkg::EV_MATCH_A] = eq_now[0] && !st_q.eq[0];
		ev_set[hibpr_pkg::EV_MATCH_B] = eq_now[1] && !st_q.eq[1];
		ev_set[hibpr_pkg::EV_LOW_BATT] = st_q.ctl[hibpr_pkg::CTL_LB_DETECT] && LOW_BATT;
		ev_set[hibpr_pkg::EV_PIN] = !WAKE_N && st_q.wake_prev;
	end

	assign ev_clr = (WR && word_ok && (ADDR == hibpr_pkg::OFF_CLEAR)) ? WDATA[hibpr_pkg::EV_W-1:0] : '0;

	assign ctl_w = WDATA[hibpr_pkg::CTL_W-1:0];
	assign lb_abort = ctl_w[hibpr_pkg::CTL_LB_ABORT] && ctl_w[hibpr_pkg::CTL_LB_DETECT] && LOW_BATT;

	// Pin level (not only its edge) resumes, so a pin held low at entry still wakes
	assign wake_req = (st_q.ctl[hibpr_pkg::CTL_PIN_RES] && !WAKE_N) ||
		(st_q.ctl[hibpr_pkg::CTL_MATCH_RES] &&
		(ev_set[hibpr_pkg::EV_MATCH_A] || ev_set[hibpr_pkg::EV_MATCH_B]));

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.osc_prev = OSC_IN;
		st_d.wake_prev = WAKE_N;
		st_d.eq = eq_now;

		// Prescaler and predivider
		if (osc_edge) begin
			st_d.div = st_q.div + 7'h01;
		end
		if (ref_tick) begin
			if (st_q.pre_cnt == '0) begin
				st_d.pre_cnt = st_q.pre_active;
			end else begin
				st_d.pre_cnt = st_q.pre_cnt - 16'h0001;
			end
		end
		if (sec_tick) begin
			st_d.sec = st_q.sec + 6'h01;
			if (st_q.sec == hibpr_pkg::SEC_LAST) begin
				st_d.pre_active = st_q.trim;
			end
			if (st_q.ctl[hibpr_pkg::CTL_COUNTER_EN]) begin
				st_d.cnt = st_q.cnt + 32'h00000001;
			end
		end

		// Register writes
		if (WR && word_ok) begin
			unique case (ADDR)
				hibpr_pkg::OFF_MATCH_A: begin
					st_d.match_a = WDATA;
				end
				hibpr_pkg::OFF_MATCH_B: begin
					st_d.match_b = WDATA;
				end
				hibpr_pkg::OFF_LOAD: begin
					st_d.load = WDATA;
					st_d.cnt = WDATA;
				end
				hibpr_pkg::OFF_CTL: begin
					st_d.ctl = ctl_w;
					// Request bit only sticks when sleep is really entered
					st_d.ctl[hibpr_pkg::CTL_SLEEP_REQ] = 1'b0;
					if (ctl_w[hibpr_pkg::CTL_SLEEP_REQ] && !lb_abort) begin
						st_d.ctl[hibpr_pkg::CTL_SLEEP_REQ] = 1'b1;
						st_d.pwr = hibpr_pkg::PWR_OFF;
					end
				end
				hibpr_pkg::OFF_MASK: begin
					st_d.mask = WDATA[hibpr_pkg::EV_W-1:0];
				end
				hibpr_pkg::OFF_TRIM: begin
					st_d.trim = WDATA[hibpr_pkg::TRIM_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Power state machine
		unique case (st_q.pwr)
			hibpr_pkg::PWR_ON: begin
			end
			hibpr_pkg::PWR_OFF: begin
				if (wake_req) begin
					st_d.pwr = hibpr_pkg::PWR_ON;
					st_d.ctl[hibpr_pkg::CTL_SLEEP_REQ] = 1'b0;
				end
			end
		endcase
		st_d.power_off_n = (st_d.pwr == hibpr_pkg::PWR_ON);

		// Sticky events: a set in the clearing cycle wins; wake keeps them pending
		st_d.raw = (st_q.raw & ~ev_clr) | ev_set;
		st_d.irq = |(st_d.raw & st_d.mask);

		// Read data, one cycle after the strobe, no spacing needed
		st_d.rd_mem = RD && in_data;
		if (RD) begin
			st_d.rdata = '0;
			if (word_ok) begin
				unique case (ADDR)
					hibpr_pkg::OFF_COUNT: begin
						st_d.rdata = st_q.cnt;
					end
					hibpr_pkg::OFF_MATCH_A: begin
						st_d.rdata = st_q.match_a;
					end
					hibpr_pkg::OFF_MATCH_B: begin
						st_d.rdata = st_q.match_b;
					end
					hibpr_pkg::OFF_LOAD: begin
						st_d.rdata = st_q.load;
					end
					hibpr_pkg::OFF_CTL: begin
						st_d.rdata = {24'h000000, st_q.ctl};
					end
					hibpr_pkg::OFF_MASK: begin
						st_d.rdata = {28'h0000000, st_q.mask};
					end
					hibpr_pkg::OFF_RAW: begin
						st_d.rdata = {28'h0000000, st_q.raw};
					end
					hibpr_pkg::OFF_MASKED: begin
						st_d.rdata = {28'h0000000, st_q.raw & st_q.mask};
					end
					hibpr_pkg::OFF_TRIM: begin
						st_d.rdata = {16'h0000, st_q.trim};
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q <= '0;
			st_q.pwr <= hibpr_pkg::PWR_ON;
			st_q.ctl <= hibpr_pkg::CTL_RST;
			st_q.cnt <= hibpr_pkg::COUNT_RST;
			st_q.match_a <= hibpr_pkg::MATCH_RST;
			st_q.match_b <= hibpr_pkg::MATCH_RST;
			st_q.load <= hibpr_pkg::LOAD_RST;
			st_q.mask <= hibpr_pkg::EV_RST;
			st_q.raw <= hibpr_pkg::EV_RST;
			st_q.trim <= hibpr_pkg::TRIM_RST;
			st_q.pre_active <= hibpr_pkg::TRIM_NOMINAL;
			st_q.pre_cnt <= hibpr_pkg::TRIM_NOMINAL;
			st_q.osc_prev <= 1'b0;
			st_q.wake_prev <= 1'b1;
			st_q.eq <= 2'h3;
			st_q.power_off_n <= 1'b1;
		end else if (CE) begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign RDATA = st_q.rd_mem ? mem_bus.rdata : st_q.rdata;
	assign POWER_OFF_N = st_q.power_off_n;
	assign IRQ = st_q.irq;

endmodule

// ---- dv/hibpr_partner.sv ----
/*
 * Far-side model: regulator rail, resume pin source and free-running reference oscillator.
 * Assumes the bench changes wake_en and wake_delay right after rising edges.
 */
module hibpr_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_off_n,
	input wire logic wake_en,
	input wire logic [7:0] wake_delay,
	output logic wake_n,
	output logic osc,
	output logic rail_on
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	logic [1:0] div_q;
	// Rail follows the enable at once; ramp time is not modelled
	assign rail_on = power_off_n;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			div_q <= 2'h0;
			osc <= 1'b0;
			wake_n <= 1'b1;
		end else begin
			div_q <= div_q + 2'h1;
			// Slow toggle keeps the reference well under half the core rate
			if (div_q == 2'h3) begin
				osc <= !osc;
			end
			if (power_off_n) begin
				cnt_q <= 8'h00;
			end else if (cnt_q != 8'hFF) begin
				cnt_q <= cnt_q + 8'h01;
			end
			// Pin held low until power is back, like a held button
			wake_n <= !(wake_en && !power_off_n && cnt_q >= wake_delay);
		end
	end
endmodule

// ---- dv/hibpr_properties.sv ----
/*
 * Checker for the hibernation power block, seeing only its top ports.
 * Assumes one clock domain and an active-low asynchronous reset.
 */
module hibpr_properties (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic [hibpr_pkg::ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic OSC_IN,
	input wire logic WAKE_N,
	input wire logic LOW_BATT,
	input wire logic POWER_OFF_N,
	input wire logic IRQ
);
	logic pin_q;
	logic match_q;
	logic mask0_q;
	logic wr_ctl;
	assign wr_ctl = CE && WR && ADDR == hibpr_pkg::OFF_CTL;
	// Shadow of resume enables and mask, since the design's copies are hidden
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pin_q <= 1'b0;
			match_q <= 1'b0;
			mask0_q <= 1'b1;
		end else begin
			if (wr_ctl) begin
				pin_q <= WDATA[hibpr_pkg::CTL_PIN_RES];
				match_q <= WDATA[hibpr_pkg::CTL_MATCH_RES];
			end
			if (CE && WR && ADDR == hibpr_pkg::OFF_MASK) begin
				mask0_q <= WDATA[3:0] == 4'h0;
			end
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	sleep_entry_a: assert property (wr_ctl && WDATA[1] && !(WDATA[7] && WDATA[5] && LOW_BATT) && WAKE_N
		&& POWER_OFF_N |=> !POWER_OFF_N) else $error("power-off not asserted after sleep request");
	abort_refuse_a: assert property (wr_ctl && WDATA[1] && WDATA[7] && WDATA[5] && LOW_BATT && POWER_OFF_N
		|=> POWER_OFF_N) else $error("sleep entered with low battery abort");
	pin_wake_a: assert property (!POWER_OFF_N && pin_q && !WAKE_N && CE && !WR |=> POWER_OFF_N)
		else $error("no wake on resume pin");
	sleep_hold_a: assert property (!POWER_OFF_N && !match_q && (WAKE_N || !pin_q) && !WR
		|=> !POWER_OFF_N) else $error("woke without an enabled source");
	mask_gate_a: assert property (mask0_q |-> !IRQ) else $error("interrupt with all events masked");
	masked_irq_a: assert property (CE && RD && ADDR == hibpr_pkg::OFF_MASKED
		|=> (RDATA != 32'h0) == $past(IRQ)) else $error("interrupt disagrees with masked status");
	clear_read_a: assert property (CE && RD && ADDR == hibpr_pkg::OFF_CLEAR |=> RDATA == 32'h0)
		else $error("clear register reads nonzero");
	load_count_a: assert property (CE && WR && ADDR == hibpr_pkg::OFF_LOAD ##1 CE && RD
		&& ADDR == hibpr_pkg::OFF_COUNT |=> RDATA == $past(WDATA, 2)) else $error("count not loaded");
	clear_pin_a: assert property (CE && WR && ADDR == hibpr_pkg::OFF_CLEAR && WDATA[3] && WAKE_N
		##1 CE && RD && ADDR == hibpr_pkg::OFF_RAW && WAKE_N |=> !RDATA[3]) else $error("pin event not cleared");
	cover property (wr_ctl && WDATA[1] ##1 !POWER_OFF_N);
	cover property (!POWER_OFF_N ##1 POWER_OFF_N);
	cover property (IRQ);
endmodule
bind hibpr_top hibpr_properties u_hibpr_properties (
	.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .OSC_IN(OSC_IN), .WAKE_N(WAKE_N), .LOW_BATT(LOW_BATT), .POWER_OFF_N(POWER_OFF_N), .IRQ(IRQ)
);

// ---- dv/hibpr_tb_top.sv ----
/*
 * Self-checking bench for the hibernation power block.
 * Assumes the checker binds itself and hibpr_partner models the far side.
 */
module hibpr_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rstn, ce, wr, rd, low_batt, wake_en, rd_d, osc_in, wake_n, power_off_n, irq;
	logic [8:0] addr;
	logic [31:0] wdata, rdata, x;
	logic [7:0] wake_delay;
	logic [31:0] mem_v [64];
	logic [31:0] exp_q [$];
	int num_errors, checks, cyc;
	// Crystal settling allowance before touching the block again
	localparam int SETTLE_CYC = 4;
	hibpr_top u_hibpr_top (.CORE_CLK(core_clk), .RSTN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .OSC_IN(osc_in), .WAKE_N(wake_n), .LOW_BATT(low_batt),
		.POWER_OFF_N(power_off_n), .IRQ(irq));
	hibpr_partner u_hibpr_partner (.clk(core_clk), .rst_n(rstn), .power_off_n(power_off_n), .wake_en(wake_en),
		.wake_delay(wake_delay), .wake_n(wake_n), .osc(osc_in), .rail_on());
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic bus(input logic w, input logic r, input logic [8:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask
	// Expected read data queued so back-to-back reads need no gap
	task automatic rdx(input logic [8:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 32'h0);
	endtask
	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, addr, wdata);
	endtask
	task automatic pwr(input logic e);
		@(negedge core_clk);
		chk({31'h0, power_off_n}, {31'h0, e});
	endtask
	task automatic wakeup;
		int n;
		n = 0;
		while (power_off_n !== 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		chk({31'h0, power_off_n}, 32'h1);
	endtask
	task automatic end_of_test;
		$display("errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge core_clk) rd_d <= rd && ce;
	always @(negedge core_clk) if (rd_d) chk(rdata, exp_q.pop_front());
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			end_of_test;
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = !core_clk;
	end
	initial begin
		{rstn, ce, wr, rd, low_batt, wake_en} = 6'h10;
		addr = 9'h000;
		wdata = 32'h0;
		wake_delay = 8'h00;
		void'($urandom(87));
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		rdx(hibpr_pkg::OFF_MATCH_A, 32'hFFFFFFFF);
		rdx(hibpr_pkg::OFF_MATCH_B, 32'hFFFFFFFF);
		rdx(hibpr_pkg::OFF_LOAD, 32'hFFFFFFFF);
		rdx(hibpr_pkg::OFF_COUNT, 32'h0);
		rdx(hibpr_pkg::OFF_TRIM, 32'h0);
		rdx(hibpr_pkg::OFF_RAW, 32'h0);
		for (int i = 0; i < 64; i++) begin
			mem_v[i] = $urandom;
			bus(1'b1, 1'b0, hibpr_pkg::OFF_DATA_LO + 9'(4 * i), mem_v[i]);
		end
		for (int i = 0; i < 64; i++) rdx(hibpr_pkg::OFF_DATA_LO + 9'(4 * i), mem_v[i]);
		x = $urandom;
		bus(1'b1, 1'b0, hibpr_pkg::OFF_TRIM, x);
		rdx(hibpr_pkg::OFF_TRIM, {16'h0, x[15:0]});
		x = $urandom;
		bus(1'b1, 1'b0, hibpr_pkg::OFF_LOAD, x);
		rdx(hibpr_pkg::OFF_COUNT, x);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_CLEAR, 32'hF);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_MATCH_B, x + 32'h5);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_MATCH_A, x);
		idle(1);
		rdx(hibpr_pkg::OFF_RAW, 32'h1);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_MASK, 32'h1);
		idle(1);
		@(negedge core_clk);
		chk({31'h0, irq}, 32'h1);
		rdx(hibpr_pkg::OFF_MASKED, 32'h1);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_MASK, 32'h2);
		rdx(hibpr_pkg::OFF_MASKED, 32'h0);
		rdx(hibpr_pkg::OFF_RAW, 32'h1);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_CLEAR, 32'h1);
		rdx(hibpr_pkg::OFF_RAW, 32'h0);
		rdx(hibpr_pkg::OFF_CLEAR, 32'h0);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_LOAD, x + 32'h5);
		idle(1);
		rdx(hibpr_pkg::OFF_MASKED, 32'h2);
		// Write while the clock enable is low must leave the count alone
		bus(1'b1, 1'b0, hibpr_pkg::OFF_LOAD, 32'h0);
		ce <= 1'b0;
		idle(1);
		ce <= 1'b1;
		rdx(hibpr_pkg::OFF_COUNT, x + 32'h5);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_CLEAR, 32'hF);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_MASK, 32'h0);
		low_batt <= 1'b1;
		bus(1'b1, 1'b0, hibpr_pkg::OFF_CTL, 32'h20);
		idle(1);
		rdx(hibpr_pkg::OFF_RAW, 32'h4);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_CTL, 32'hE2);
		idle(SETTLE_CYC);
		pwr(1'b1);
		rdx(hibpr_pkg::OFF_CTL, 32'hE0);
		low_batt <= 1'b0;
		bus(1'b1, 1'b0, hibpr_pkg::OFF_CTL, 32'h0);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_CLEAR, 32'h4);
		rdx(hibpr_pkg::OFF_RAW, 32'h0);
		wake_en <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wake_delay <= 8'(2 + $urandom_range(40));
			bus(1'b1, 1'b0, hibpr_pkg::OFF_CTL, i[0] ? 32'hF6 : 32'h56);
			idle(1);
			pwr(1'b0);
			wakeup;
			rdx(hibpr_pkg::OFF_RAW, 32'h8);
			rdx(hibpr_pkg::OFF_CTL, i[0] ? 32'hF4 : 32'h54);
			bus(1'b1, 1'b0, hibpr_pkg::OFF_CLEAR, 32'h8);
			rdx(hibpr_pkg::OFF_RAW, 32'h0);
		end
		// Pin falls during the match-only sleep, so raw shows both events
		wake_delay <= 8'h04;
		bus(1'b1, 1'b0, hibpr_pkg::OFF_CTL, 32'h4A);
		idle(12);
		pwr(1'b0);
		bus(1'b1, 1'b0, hibpr_pkg::OFF_LOAD, x);
		idle(1);
		wakeup;
		rdx(hibpr_pkg::OFF_RAW, 32'h9);
		idle(3);
		end_of_test;
	end
endmodule
